//--- qdie_top.sv
// The APB interface to the registers was chosen for this implementation.
`default_nettype none
module qdie_top
    import qdie_pkg::*;
#(
    parameter int MOTION_W = 16,
    parameter int DBL_W = 4
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_ready_evt,
    input wire logic count_overflow_evt,
    input wire logic stopped_evt,
    input wire logic [MOTION_W-1:0] motion_total,
    input wire logic [DBL_W-1:0] double_transition_total,
    output logic report_ready_evt,
    output logic double_ready_evt,
    output logic irq
);
    logic [EVT_N-1:0] enable_reg;
    logic [EVT_N-1:0] enable_next;
    logic [PERIOD_W-1:0] report_period_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic irq_cond;
    logic access;
    logic wr_fire;
    logic rd_load;
    logic hit_set;
    logic hit_clr;
    logic hit_status;
    logic hit_period;
    logic mapped;
    logic [EVT_N-1:0] wr_bits;
    logic [EVT_N-1:0] evt_pulse;
    logic [EVT_N-1:0] flags;
    logic gen_report;
    logic gen_double;

    if (MOTION_W < 1 || DBL_W < 1)
    begin : g_bad_w
        $error("qdie_top accumulator widths must be at least one.");
    end

    function automatic logic [DATA_W-1:0] widen(input logic [EVT_N-1:0] v);
        widen = {{(DATA_W-EVT_N){1'b0}}, v};
    endfunction

    assign hit_set = paddr == OFF_ENABLE_SET;
    assign hit_clr = paddr == OFF_ENABLE_CLR;
    assign hit_status = paddr == OFF_EVT_STATUS;
    assign hit_period = paddr == OFF_REPORT_PERIOD;
    assign mapped = hit_set || hit_clr || hit_status || hit_period;
    assign wr_bits = pwdata[EVT_N-1:0];

    // The slave adds one wait state so that read data always leave a flip-flop.
    assign access = psel && penable;
    assign rd_load = access && !pready_reg;
    assign wr_fire = access && pready_reg && pwrite && mapped;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pready_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= rd_load;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pslverr_reg <= rd_load && !mapped;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            prdata_reg <= READ_ZERO;
        end
        else if (rd_load && !pwrite)
        begin
            if (hit_set || hit_clr)
            begin
                prdata_reg <= widen(enable_reg);
            end
            else if (hit_status)
            begin
                prdata_reg <= widen(flags);
            end
            else if (hit_period)
            begin
                prdata_reg <= {{(DATA_W-PERIOD_W){1'b0}}, report_period_reg};
            end
            else
            begin
                prdata_reg <= READ_ZERO;
            end
        end
    end

    always_comb
    begin
        enable_next = enable_reg;
        if (wr_fire && hit_set)
        begin
            enable_next = enable_reg | wr_bits;
        end
        else if (wr_fire && hit_clr)
        begin
            enable_next = enable_reg & ~wr_bits;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            enable_reg <= ENABLE_RST;
        end
        else
        begin
            enable_reg <= enable_next;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            report_period_reg <= PERIOD_RST;
        end
        else if (wr_fire && hit_period)
        begin
            report_period_reg <= pwdata[PERIOD_W-1:0];
        end
    end

    qdie_report_gen #(
        .PW(PERIOD_W),
        .MOTION_W(MOTION_W),
        .DBL_W(DBL_W)
    ) u_report_gen (
        .clock(clock),
        .rst_n(rst_n),
        .sample_ready_evt(sample_ready_evt),
        .report_period(report_period_reg),
        .motion_total(motion_total),
        .double_transition_total(double_transition_total),
        .report_ready_evt(gen_report),
        .double_ready_evt(gen_double)
    );

    always_comb
    begin
        evt_pulse = '0;
        evt_pulse[EVT_SAMPLE] = sample_ready_evt;
        evt_pulse[EVT_REPORT] = gen_report;
        evt_pulse[EVT_OVERFLOW] = count_overflow_evt;
        evt_pulse[EVT_DOUBLE] = gen_double;
        evt_pulse[EVT_STOPPED] = stopped_evt;
    end

    // Flags record every event even when disabled, so enabling later raises a pending request.
    qdie_event_flags #(
        .N(EVT_N)
    ) u_flags (
        .clock(clock),
        .rst_n(rst_n),
        .set_pulse(evt_pulse),
        .clr_valid(wr_fire && hit_status),
        .clr_mask(wr_bits),
        .flags(flags)
    );

    assign irq_cond = |(flags & enable_reg);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_cond;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign report_ready_evt = gen_report;
    assign double_ready_evt = gen_double;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic wr_set;
    logic wr_clr;
    logic rd_enable;
    logic rd_status;
    logic wr_stray;
    assign wr_set = wr_fire && hit_set;
    assign wr_clr = wr_fire && hit_clr;
    assign rd_enable = rd_load && !pwrite && (hit_set || hit_clr);
    assign rd_status = rd_load && !pwrite && hit_status;
    assign wr_stray = access && pready_reg && pwrite && !mapped;

    enable_set_a: assert property (
        wr_set |=> (enable_reg == ($past(enable_reg) | $past(wr_bits))))
        else $error("Enable set write did not take effect.");

    enable_clear_a: assert property (
        wr_clr |=> (enable_reg == ($past(enable_reg) & ~$past(wr_bits))))
        else $error("Enable clear write did not take effect.");

    enable_read_a: assert property (
        rd_enable |=> pready_reg && (prdata_reg == widen($past(enable_reg))))
        else $error("Enable readback does not match enables.");

    overflow_bit_a: assert property (
        (wr_set && wr_bits == 5'h04) |=> enable_reg[EVT_OVERFLOW]
            && enable_reg[1:0] == $past(enable_reg[1:0])
            && enable_reg[4:3] == $past(enable_reg[4:3]))
        else $error("Overflow enable is not separate.");

    overflow_clear_a: assert property (
        (wr_clr && wr_bits[EVT_OVERFLOW]) |=> !enable_reg[EVT_OVERFLOW])
        else $error("Overflow enable did not clear.");

    stopped_bit_a: assert property (
        (wr_set && wr_bits == 5'h10) |=> enable_reg[EVT_STOPPED]
            && enable_reg[3:0] == $past(enable_reg[3:0]))
        else $error("Stopped enable is not separate.");

    double_bit_a: assert property (
        (wr_clr && wr_bits[EVT_DOUBLE]) |=> !enable_reg[EVT_DOUBLE])
        else $error("Double enable did not clear.");

    zero_write_a: assert property (
        ((wr_set || wr_clr) && wr_bits == '0) |=> $stable(enable_reg))
        else $error("A zero write changed the enables.");

    irq_level_a: assert property (
        irq_reg == $past(irq_cond))
        else $error("Interrupt request does not follow enabled flags.");

    answer_time_a: assert property (
        (psel && !penable) ##1 access |=> pready_reg)
        else $error("Slave did not answer after one wait state.");

    period_write_a: assert property (
        (wr_fire && hit_period) |=> report_period_reg == $past(pwdata[PERIOD_W-1:0]))
        else $error("Report period write was lost.");

    stopped_clear_a: assert property (
        (wr_clr && wr_bits[EVT_STOPPED]) |=> !enable_reg[EVT_STOPPED])
        else $error("Stopped enable did not clear.");

    double_set_a: assert property (
        (wr_set && wr_bits[EVT_DOUBLE]) |=> enable_reg[EVT_DOUBLE])
        else $error("Double enable did not set.");

    enable_idle_a: assert property (
        !(wr_set || wr_clr) |=> $stable(enable_reg))
        else $error("Enables changed without a write.");

    irq_rise_a: assert property (
        (|(flags & enable_reg)) |=> irq_reg)
        else $error("Interrupt request missing for an enabled flag.");

    irq_fall_a: assert property (
        ((flags & enable_reg) == '0) |=> !irq_reg)
        else $error("Interrupt request without an enabled flag.");

    status_read_a: assert property (
        rd_status |=> pready_reg && (prdata_reg == widen($past(flags))))
        else $error("Status readback does not match flags.");

    status_clear_a: assert property (
        (wr_fire && hit_status && evt_pulse == '0) |=> (flags & $past(wr_bits)) == '0)
        else $error("Status clear write did not clear.");

    error_flag_a: assert property (
        (rd_load && !mapped) |=> pready_reg && pslverr_reg)
        else $error("Unmapped access was not refused.");

    error_quiet_a: assert property (
        (rd_load && mapped) |=> !pslverr_reg)
        else $error("Mapped access was refused.");

    ready_pulse_a: assert property (
        pready_reg |=> !pready_reg)
        else $error("Ready stood longer than one cycle.");

    stray_write_a: assert property (
        wr_stray |=> $stable(enable_reg) && $stable(report_period_reg))
        else $error("Unmapped write changed a register.");

    read_hold_a: assert property (
        !(rd_load && !pwrite) |=> $stable(prdata_reg))
        else $error("Read data changed outside a read.");
endmodule
`default_nettype wire

//--- qdie_pkg.sv
`default_nettype none
package qdie_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int EVT_N = 5;
    localparam int PERIOD_W = 8;
    localparam logic [ADDR_W-1:0] OFF_ENABLE_SET = 12'h304;
    localparam logic [ADDR_W-1:0] OFF_ENABLE_CLR = 12'h308;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS = 12'h30C;
    localparam logic [ADDR_W-1:0] OFF_REPORT_PERIOD = 12'h510;
    localparam int EVT_SAMPLE = 0;
    localparam int EVT_REPORT = 1;
    localparam int EVT_OVERFLOW = 2;
    localparam int EVT_DOUBLE = 3;
    localparam int EVT_STOPPED = 4;
    localparam logic [EVT_N-1:0] ENABLE_RST = 5'h00;
    localparam logic [EVT_N-1:0] STATUS_RST = 5'h00;
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 8'h01;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

//--- qdie_event_flags.sv
`default_nettype none
module qdie_event_flags
    import qdie_pkg::*;
#(
    parameter int N = EVT_N
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [N-1:0] set_pulse,
    input wire logic clr_valid,
    input wire logic [N-1:0] clr_mask,
    output logic [N-1:0] flags
);
    logic [N-1:0] flags_reg;
    logic [N-1:0] flags_next;

    if (N < 1)
    begin : g_bad_n
        $error("qdie_event_flags needs at least one flag.");
    end

    // A clear that meets a new event in the same cycle must not lose it.
    always_comb
    begin
        flags_next = flags_reg;
        if (clr_valid)
        begin
            flags_next = flags_next & ~clr_mask;
        end
        flags_next = flags_next | set_pulse;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            flags_reg <= '0;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    assign flags = flags_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    set_wins_a: assert property (
        (set_pulse != '0) |=> ((flags_reg & $past(set_pulse)) == $past(set_pulse)))
        else $error("A set event was lost.");
endmodule
`default_nettype wire

//--- qdie_report_gen.sv
`default_nettype none
module qdie_report_gen
    import qdie_pkg::*;
#(
    parameter int PW = PERIOD_W,
    parameter int MOTION_W = 16,
    parameter int DBL_W = 4
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sample_ready_evt,
    input wire logic [PW-1:0] report_period,
    input wire logic [MOTION_W-1:0] motion_total,
    input wire logic [DBL_W-1:0] double_transition_total,
    output logic report_ready_evt,
    output logic double_ready_evt
);
    logic [PW-1:0] count_reg;
    logic report_reg;
    logic double_reg;
    logic period_done;

    if (PW < 1 || MOTION_W < 1 || DBL_W < 1)
    begin : g_bad_w
        $error("qdie_report_gen widths must be at least one.");
    end

    // A period of zero behaves as one sample, so the count never runs away.
    function automatic logic reached(input logic [PW-1:0] cnt, input logic [PW-1:0] per);
        reached = ({1'b0, cnt} + {{PW{1'b0}}, 1'b1}) >= {1'b0, per};
    endfunction

    assign period_done = sample_ready_evt && reached(count_reg, report_period);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
        end
        else if (period_done)
        begin
            count_reg <= '0;
        end
        else if (sample_ready_evt)
        begin
            count_reg <= count_reg + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            report_reg <= 1'b0;
            double_reg <= 1'b0;
        end
        else
        begin
            report_reg <= period_done && (motion_total != '0);
            double_reg <= period_done && (double_transition_total != '0);
        end
    end

    assign report_ready_evt = report_reg;
    assign double_ready_evt = double_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic motion_any;
    logic double_any;
    assign motion_any = motion_total != '0;
    assign double_any = double_transition_total != '0;

    report_cause_a: assert property (
        report_reg |-> $past(period_done) && $past(motion_any))
        else $error("Report event without a full period of motion.");
    double_cause_a: assert property (
        double_reg |-> $past(period_done) && $past(double_any))
        else $error("Double event without a full period of transitions.");
    period_count_a: assert property (
        (sample_ready_evt && !period_done) |=> count_reg == $past(count_reg) + 1'b1)
        else $error("Sample count did not advance.");
endmodule
`default_nettype wire

//--- qdie_top_test.sv
`default_nettype none
module qdie_top_test
    import qdie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 12'h000;
    logic [DATA_W-1:0] pwdata = 32'h0000_0000;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic sample_ready_evt = 1'b0;
    logic count_overflow_evt = 1'b0;
    logic stopped_evt = 1'b0;
    logic [15:0] motion_total = 16'h0000;
    logic [3:0] double_transition_total = 4'h0;
    logic report_ready_evt;
    logic double_ready_evt;
    logic irq;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    qdie_top qdie_top_i (
        .clock(clock),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .sample_ready_evt(sample_ready_evt),
        .count_overflow_evt(count_overflow_evt),
        .stopped_evt(stopped_evt),
        .motion_total(motion_total),
        .double_transition_total(double_transition_total),
        .report_ready_evt(report_ready_evt),
        .double_ready_evt(double_ready_evt),
        .irq(irq)
    );

    always #5 clock = ~clock;

    task automatic wrap_up();
        if (errors == 0 && compares > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // The ceiling is far above the few hundred cycles the tests need.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until pready is seen high, with an idle cycle after it.
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       output logic [DATA_W-1:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
        begin
            @(posedge clock);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(r, exp);
        check({31'h0000_0000, e}, 32'h0000_0000);
    endtask

    // The irq output follows its cause one cycle late, so two edges are let pass.
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clock);
        check({31'h0000_0000, irq}, {31'h0000_0000, exp});
    endtask

    task automatic reset_values();
        rd_chk(OFF_ENABLE_SET, 32'h0000_0000);
        rd_chk(OFF_ENABLE_CLR, 32'h0000_0000);
        rd_chk(OFF_REPORT_PERIOD, 32'h0000_0001);
        check({31'h0000_0000, irq}, 32'h0000_0000);
    endtask

    task automatic set_clear_bits();
        logic [DATA_W-1:0] en;
        en = 32'h0000_0000;
        for (int i = 0; i < EVT_N; i++)
        begin
            en = en | (32'h0000_0001 << i);
            wr(OFF_ENABLE_SET, 32'h0000_0001 << i);
            rd_chk(OFF_ENABLE_SET, en);
            wr(OFF_ENABLE_SET, 32'h0000_0000);
            rd_chk(OFF_ENABLE_CLR, en);
        end
        for (int i = 0; i < EVT_N; i++)
        begin
            en = en & ~(32'h0000_0001 << i);
            wr(OFF_ENABLE_CLR, 32'h0000_0001 << i);
            rd_chk(OFF_ENABLE_CLR, en);
            wr(OFF_ENABLE_CLR, 32'h0000_0000);
            rd_chk(OFF_ENABLE_SET, en);
        end
    endtask

    task automatic pulse_sample(input logic exp_rep, input logic exp_dbl);
        sample_ready_evt <= 1'b1;
        @(posedge clock);
        sample_ready_evt <= 1'b0;
        @(posedge clock);
        check({31'h0000_0000, report_ready_evt}, {31'h0000_0000, exp_rep});
        check({31'h0000_0000, double_ready_evt}, {31'h0000_0000, exp_dbl});
    endtask

    task automatic report_events();
        wr(OFF_REPORT_PERIOD, 32'h0000_0003);
        motion_total <= 16'h0005;
        double_transition_total <= 4'h0;
        pulse_sample(1'b0, 1'b0);
        pulse_sample(1'b0, 1'b0);
        pulse_sample(1'b1, 1'b0);
        motion_total <= 16'h0000;
        double_transition_total <= 4'h2;
        pulse_sample(1'b0, 1'b0);
        pulse_sample(1'b0, 1'b0);
        pulse_sample(1'b0, 1'b1);
        rd_chk(OFF_EVT_STATUS, 32'h0000_000B);
        wr(OFF_ENABLE_SET, 32'h0000_000B);
        irq_chk(1'b1);
        wr(OFF_ENABLE_CLR, 32'h0000_000B);
        irq_chk(1'b0);
        wr(OFF_EVT_STATUS, 32'h0000_001F);
        rd_chk(OFF_EVT_STATUS, 32'h0000_0000);
    endtask

    task automatic irq_path(input int bit_i);
        logic [DATA_W-1:0] m;
        m = 32'h0000_0001 << bit_i;
        if (bit_i == EVT_OVERFLOW)
        begin
            count_overflow_evt <= 1'b1;
        end
        else
        begin
            stopped_evt <= 1'b1;
        end
        @(posedge clock);
        count_overflow_evt <= 1'b0;
        stopped_evt <= 1'b0;
        irq_chk(1'b0);
        wr(OFF_ENABLE_SET, m);
        irq_chk(1'b1);
        wr(OFF_ENABLE_CLR, m);
        irq_chk(1'b0);
        wr(OFF_ENABLE_SET, m);
        irq_chk(1'b1);
        wr(OFF_EVT_STATUS, m);
        irq_chk(1'b0);
        wr(OFF_ENABLE_CLR, m);
    endtask

    task automatic unmapped_access();
        logic [DATA_W-1:0] r;
        logic e;
        apb(1'b0, 12'h400, 32'h0000_0000, r, e);
        check(r, 32'h0000_0000);
        check({31'h0000_0000, e}, 32'h0000_0001);
        apb(1'b1, 12'h400, 32'h0000_001F, r, e);
        check({31'h0000_0000, e}, 32'h0000_0001);
        rd_chk(OFF_ENABLE_SET, 32'h0000_0000);
    endtask

    initial
    begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        reset_values();
        set_clear_bits();
        report_events();
        irq_path(EVT_OVERFLOW);
        irq_path(EVT_STOPPED);
        unmapped_access();
        wrap_up();
    end
endmodule
`default_nettype wire
